// *** emt_params.svh ***
// constants for the eeprom status and margin test register block
// assumes includers use `define names directly; no other header defines them
`ifndef EMT_PARAMS_SVH
`define EMT_PARAMS_SVH

`define EMT_OFS_TEST        8'h40
`define EMT_OFS_FAILED      8'h41
`define EMT_OFS_STATUS      8'h42
`define EMT_OFS_MARGIN      8'h43
`define EMT_OFS_IRQ_STATUS  8'h48
`define EMT_OFS_IRQ_MASK    8'h49

`define EMT_TEST_OUT_DIS    0
`define EMT_TEST_NOM_COMM   22

`define EMT_ST_DBE          0
`define EMT_ST_SBE          1
`define EMT_ST_WERR         2
`define EMT_ST_CODE_LSB     3
`define EMT_ST_ADDR_LSB     8
`define EMT_ST_ECC_LSB      13
`define EMT_ST_PUMP         19

`define EMT_MG_START        0
`define EMT_MG_NO_MAX       1
`define EMT_MG_NO_MIN       2
`define EMT_MG_STAT_LSB     3
`define EMT_MG_MINMAX       5
`define EMT_MG_FIRST_SEL    6
`define EMT_MG_FIRST_LSB    7
`define EMT_MG_REPEAT       13

`define EMT_MS_NONE         2'h0
`define EMT_MS_PASS         2'h1
`define EMT_MS_FAIL         2'h2
`define EMT_MS_RUN          2'h3

`define EMT_LAST_ADDR       5'h1F
`define EMT_IRQ_W           5

`endif

// *** emt_pkg.sv ***
// types shared by the eeprom status and margin test register block
// assumes emt_params.svh is not needed for the types
`default_nettype none

package emt_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } emt_bus_req_s;

    typedef struct packed {
        logic [25:0] word;
        logic [5:0]  check;
        logic        sbe;
        logic        dbe;
        logic        bad_min;
        logic        bad_max;
    } emt_nvm_rsp_s;

    typedef enum logic [2:0] {
        EMT_IDLE = 3'b001,
        EMT_READ = 3'b010,
        EMT_WAIT = 3'b100
    } emt_state_e;

endpackage

`default_nettype wire

// *** emt_regs.sv ***
// eeprom test, status and margin test registers with a margin test sequencer
// assumes one clock, synchronous inputs and a nvm reader answering each read with a valid pulse
//
// Function
// - out_dis bit suppresses sensor output
// - bit 22 allows communication at nominal supply
// - failing 26-bit word captured into data register
// - double-bit error flag latched and held
// - single-bit error flag latched and held
// - write error flag latched, cleared on read
// - factory code shown while write error set
// - address field for manual write, failing address
// - check bits for manual write, captured failure
// - pump ramp fault flag, clear on read; its code is captured but shows only while write error set
// - repeat bit loops margin test until failure
// - start at zero or chosen first address
// - bit 5 tells min or max failed
// - start bit begins, self clears, failure clears
// - margin status code, cleared on read
`include "emt_params.svh"
`timescale 1ns/1ps
`default_nettype none

module emt_regs
#(
    parameter int NVM_ADDR_W = 5,
    parameter int WORD_W     = 26,
    parameter int CHECK_W    = 6,
    parameter int IRQ_W      = `EMT_IRQ_W
)
(
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire emt_pkg::emt_bus_req_s bus_req,
    output logic [31:0]               rdata,
    output logic                      output_disable,
    output logic                      nominal_comm_enable,
    output logic                      nominal_comm_allow,
    input  wire logic                 supply_raised,
    output logic                      nvm_rd,
    output logic [4:0]                nvm_addr,
    output logic                      nvm_ref_max,
    input  wire logic                 nvm_valid,
    input  wire emt_pkg::emt_nvm_rsp_s nvm_rsp,
    input  wire logic                 self_check_fail,
    input  wire logic [4:0]           self_check_addr,
    input  wire logic                 write_fault,
    input  wire logic                 pump_fault,
    input  wire logic [4:0]           fault_code,
    output logic [4:0]                manual_addr,
    output logic [5:0]                manual_check,
    output logic                      irq
);

    ////////////////////////////////////////////////////////////////////////
    // the register layout and the struct carriers fix these sizes, so anything else is refused
    generate
        if (NVM_ADDR_W != 5)
        begin : g_bad_addr_w
            $error("emt_regs: nvm address width must be 5");
        end
        if (WORD_W != 26)
        begin : g_bad_word_w
            $error("emt_regs: failed word width must be 26");
        end
        if (CHECK_W != 6)
        begin : g_bad_check_w
            $error("emt_regs: check bit width must be 6");
        end
        if (IRQ_W != 5)
        begin : g_bad_irq_w
            $error("emt_regs: five interrupt sources need five status bits");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    logic        wr_test;
    logic        wr_failed;
    logic        wr_status;
    logic        wr_margin;
    logic        wr_mask;
    logic        rd_status;
    logic        rd_margin;
    logic        rd_irq;
    assign wr_test   = bus_req.wr && hit(bus_req.addr, `EMT_OFS_TEST);
    assign wr_failed = bus_req.wr && hit(bus_req.addr, `EMT_OFS_FAILED);
    assign wr_status = bus_req.wr && hit(bus_req.addr, `EMT_OFS_STATUS);
    assign wr_margin = bus_req.wr && hit(bus_req.addr, `EMT_OFS_MARGIN);
    assign wr_mask   = bus_req.wr && hit(bus_req.addr, `EMT_OFS_IRQ_MASK);
    assign rd_status = bus_req.rd && hit(bus_req.addr, `EMT_OFS_STATUS);
    assign rd_margin = bus_req.rd && hit(bus_req.addr, `EMT_OFS_MARGIN);
    assign rd_irq    = bus_req.rd && hit(bus_req.addr, `EMT_OFS_IRQ_STATUS);

    ////////////////////////////////////////////////////////////////////////
    // test register
    logic [31:0] test_control;
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            test_control <= 32'h0;
        else if (wr_test)
            test_control <= bus_req.wdata;
    end
    assign output_disable      = test_control[`EMT_TEST_OUT_DIS];
    assign nominal_comm_enable = test_control[`EMT_TEST_NOM_COMM];
    assign nominal_comm_allow  = supply_raised || test_control[`EMT_TEST_NOM_COMM];

    ////////////////////////////////////////////////////////////////////////
    // margin sequencer
    emt_pkg::emt_state_e state;
    logic [4:0]  cur_addr;
    logic        phase_max;
    logic        run;
    logic        repeat_en;
    logic        first_sel;
    logic [4:0]  first_addr;
    logic        no_min;
    logic        no_max;
    logic        minmax_fail;
    logic [1:0]  margin_status;
    logic        fail_now;
    logic        pass_done;
    logic        last_phase;
    logic [4:0]  start_addr;

    assign start_addr = first_sel ? first_addr : 5'h0;
    assign last_phase = phase_max || no_max;
    assign fail_now   = (state == emt_pkg::EMT_WAIT) && nvm_valid &&
                        (phase_max ? nvm_rsp.bad_max : nvm_rsp.bad_min);
    assign pass_done  = (state == emt_pkg::EMT_WAIT) && nvm_valid && !fail_now &&
                        last_phase && (cur_addr == `EMT_LAST_ADDR) && !repeat_en;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            run        <= 1'b0;
            repeat_en  <= 1'b0;
            first_sel  <= 1'b0;
            first_addr <= 5'h0;
            no_min     <= 1'b0;
            no_max     <= 1'b0;
        end
        else
        begin
            if (wr_margin)
            begin
                repeat_en  <= bus_req.wdata[`EMT_MG_REPEAT];
                first_sel  <= bus_req.wdata[`EMT_MG_FIRST_SEL];
                first_addr <= bus_req.wdata[`EMT_MG_FIRST_LSB +: 5];
                no_min     <= bus_req.wdata[`EMT_MG_NO_MIN];
                no_max     <= bus_req.wdata[`EMT_MG_NO_MAX];
            end
            // failure or the passing last read of a non-repeating pass clears the start bit over a write
            if (fail_now || pass_done)
                run <= 1'b0;
            else if (wr_margin)
                run <= bus_req.wdata[`EMT_MG_START];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state     <= emt_pkg::EMT_IDLE;
            cur_addr  <= 5'h0;
            phase_max <= 1'b0;
        end
        else
        begin
            unique case (state)
                emt_pkg::EMT_IDLE:
                begin
                    if (run && !(no_min && no_max))
                    begin
                        cur_addr  <= start_addr;
                        phase_max <= no_min;
                        state     <= emt_pkg::EMT_READ;
                    end
                end
                emt_pkg::EMT_READ:
                    state <= run ? emt_pkg::EMT_WAIT : emt_pkg::EMT_IDLE;
                emt_pkg::EMT_WAIT:
                begin
                    if (nvm_valid)
                    begin
                        if (fail_now || pass_done || !run)
                            state <= emt_pkg::EMT_IDLE;
                        else
                        begin
                            state <= emt_pkg::EMT_READ;
                            if (!phase_max && !no_max)
                                phase_max <= 1'b1;
                            else
                            begin
                                // wrapping past the last word is the looping case
                                phase_max <= no_min;
                                cur_addr  <= cur_addr + 5'h1;
                            end
                        end
                    end
                end
            endcase
        end
    end
    assign nvm_rd      = (state == emt_pkg::EMT_READ) && run;
    assign nvm_addr    = cur_addr;
    assign nvm_ref_max = phase_max;

    // status code: a result beats running, running beats the read clear, result held until read
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            margin_status <= `EMT_MS_NONE;
            minmax_fail   <= 1'b0;
        end
        else
        begin
            if (fail_now)
            begin
                margin_status <= `EMT_MS_FAIL;
                minmax_fail   <= phase_max;
            end
            else if (pass_done)
                margin_status <= `EMT_MS_PASS;
            else if (run)
                margin_status <= `EMT_MS_RUN;
            else if (rd_margin)
                margin_status <= `EMT_MS_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // captured data and eeprom status
    logic [25:0] failed_word;
    logic        double_error_flag;
    logic        single_error_flag;
    logic        write_fault_flag;
    logic        pump_ramp_fault;
    logic [4:0]  write_fault_code;
    logic [4:0]  nvm_word_address;
    logic [5:0]  nvm_check_bits;
    logic        cap;
    assign cap = fail_now || self_check_fail;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            failed_word <= 26'h0;
        else if (cap)
            failed_word <= nvm_rsp.word;
        else if (wr_failed)
            failed_word <= bus_req.wdata[25:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            double_error_flag <= 1'b0;
            single_error_flag <= 1'b0;
            write_fault_flag  <= 1'b0;
            pump_ramp_fault   <= 1'b0;
            write_fault_code  <= 5'h0;
            nvm_word_address  <= 5'h0;
            nvm_check_bits    <= 6'h0;
        end
        else
        begin
            // sticky flags: hardware set beats software write or read clear
            if (nvm_valid && nvm_rsp.dbe)
                double_error_flag <= 1'b1;
            else if (wr_status)
                double_error_flag <= bus_req.wdata[`EMT_ST_DBE];
            if (nvm_valid && nvm_rsp.sbe)
                single_error_flag <= 1'b1;
            else if (wr_status)
                single_error_flag <= bus_req.wdata[`EMT_ST_SBE];
            if (write_fault)
                write_fault_flag <= 1'b1;
            else if (rd_status)
                write_fault_flag <= 1'b0;
            if (pump_fault)
                pump_ramp_fault <= 1'b1;
            else if (rd_status)
                pump_ramp_fault <= 1'b0;
            if (write_fault || pump_fault)
                write_fault_code <= fault_code;
            if (cap)
            begin
                nvm_word_address <= fail_now ? cur_addr : self_check_addr;
                nvm_check_bits   <= nvm_rsp.check;
            end
            else if (wr_status)
            begin
                nvm_word_address <= bus_req.wdata[`EMT_ST_ADDR_LSB +: 5];
                nvm_check_bits   <= bus_req.wdata[`EMT_ST_ECC_LSB +: 6];
            end
        end
    end
    assign manual_addr  = nvm_word_address;
    assign manual_check = nvm_check_bits;

    ////////////////////////////////////////////////////////////////////////
    // interrupts: dbe, sbe, write fault, pump fault, margin fail
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_event;
    assign irq_event = {fail_now, pump_fault, write_fault,
                        nvm_valid && nvm_rsp.sbe, nvm_valid && nvm_rsp.dbe};
    // one sticky bit per source; an event in the clearing read's cycle survives it
    generate
        for (genvar i = 0; i < IRQ_W; i++)
        begin : g_irq_bit
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                    irq_status[i] <= 1'b0;
                else if (irq_event[i])
                    irq_status[i] <= 1'b1;
                else if (rd_irq)
                    irq_status[i] <= 1'b0;
            end
        end
    endgenerate
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            irq_mask <= '0;
        else if (wr_mask)
            irq_mask <= bus_req.wdata[IRQ_W-1:0];
    end
    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe; unmapped reads zero
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = 32'h0;
        if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                `EMT_OFS_TEST:       next_rdata = test_control;
                `EMT_OFS_FAILED:     next_rdata = {6'h0, failed_word};
                `EMT_OFS_STATUS:     next_rdata = {12'h0, pump_ramp_fault, nvm_check_bits, nvm_word_address,
                                                   write_fault_flag ? write_fault_code : 5'h0,
                                                   write_fault_flag, single_error_flag, double_error_flag};
                `EMT_OFS_MARGIN:     next_rdata = {18'h0, repeat_en, 1'b0, first_addr, first_sel, minmax_fail,
                                                   margin_status, no_min, no_max, run};
                `EMT_OFS_IRQ_STATUS: next_rdata = {27'h0, irq_status};
                `EMT_OFS_IRQ_MASK:   next_rdata = {27'h0, irq_mask};
                default:             next_rdata = 32'h0;
            endcase
        end
    end
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rdata <= 32'h0;
        else
            rdata <= next_rdata;
    end

endmodule // emt_regs

`default_nettype wire

// *** emt_regs_chk.sv ***
// assertions on the ports of the eeprom status and margin test registers
// assumes one clock, synchronous active-high reset, bound to every emt_regs
`timescale 1ns/1ps
`default_nettype none
`include "emt_params.svh"

module emt_regs_chk
(
    input wire logic                  clk_sys,
    input wire logic                  rst,
    input wire emt_pkg::emt_bus_req_s bus_req,
    input wire logic [31:0]           rdata,
    input wire logic                  output_disable,
    input wire logic                  nominal_comm_enable,
    input wire logic                  nominal_comm_allow,
    input wire logic                  supply_raised,
    input wire logic                  nvm_rd,
    input wire logic [4:0]            nvm_addr,
    input wire logic                  nvm_ref_max,
    input wire logic                  nvm_valid,
    input wire emt_pkg::emt_nvm_rsp_s nvm_rsp,
    input wire logic                  write_fault,
    input wire logic                  pump_fault
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic w40;
    logic r42;
    logic w42;
    logic w43;
    logic flt;
    assign w40 = bus_req.wr && bus_req.addr == `EMT_OFS_TEST;
    assign r42 = bus_req.rd && bus_req.addr == `EMT_OFS_STATUS;
    assign w42 = bus_req.wr && bus_req.addr == `EMT_OFS_STATUS;
    assign w43 = bus_req.wr && bus_req.addr == `EMT_OFS_MARGIN;
    assign flt = write_fault || pump_fault;

    ////////////////////////////////////////////////////////////////////////
    a_out_dis_follow: assert property (w40 |=> output_disable == $past(bus_req.wdata[0]))
        else $error("output disable wrong");
    a_comm_allow_or: assert property (nominal_comm_allow == (supply_raised || nominal_comm_enable))
        else $error("comm allow wrong");
    a_rdata_idle: assert property (!bus_req.rd |=> rdata == 32'h0)
        else $error("rdata not zero");
    a_werr_latch: assert property (write_fault ##1 !r42 ##1 r42 |=> rdata[2])
        else $error("write fault not latched");
    // a fault in either read cycle wins over the clear, so both are excluded
    a_rc_clear: assert property ((r42 && !flt) ##1 !flt ##1 (r42 && !flt) |=> !rdata[2] && !rdata[19])
        else $error("flag not cleared on read");
    a_dbe_held: assert property ((nvm_valid && nvm_rsp.dbe) ##1 (!w42 && !r42) ##1 r42 |=> rdata[0])
        else $error("double error not latched");
    a_sbe_held: assert property ((nvm_valid && nvm_rsp.sbe) ##1 (!w42 && !r42) ##1 r42 |=> rdata[1])
        else $error("single error not latched");
    a_nvm_rd_pulse: assert property (nvm_rd |=> !nvm_rd)
        else $error("nvm read longer than a cycle");
    a_first_addr_pick: assert property (w43 && bus_req.wdata[0] && !bus_req.wdata[2]
        |-> ##2 nvm_rd && !nvm_ref_max
        && nvm_addr == ($past(bus_req.wdata[6], 2) ? $past(bus_req.wdata[11:7], 2) : 5'h0))
        else $error("margin start address wrong");

    c_margin_max_fail: cover property (nvm_valid && nvm_rsp.bad_max);
    c_fault_read: cover property (write_fault ##2 r42);
    c_pump_fault: cover property (pump_fault);
endmodule // emt_regs_chk

bind emt_regs emt_regs_chk emt_regs_chk_inst (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .output_disable(output_disable), .nominal_comm_enable(nominal_comm_enable),
    .nominal_comm_allow(nominal_comm_allow), .supply_raised(supply_raised), .nvm_rd(nvm_rd),
    .nvm_addr(nvm_addr), .nvm_ref_max(nvm_ref_max), .nvm_valid(nvm_valid), .nvm_rsp(nvm_rsp),
    .write_fault(write_fault), .pump_fault(pump_fault));
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the eeprom status and margin test registers
// assumes emt_regs with its checker bound; the bench plays the nvm reader itself
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic                  clk_sys, rst, supply_raised, nvm_valid, write_fault, pump_fault, irq, self_check_fail;
    logic                  output_disable, nominal_comm_enable, nominal_comm_allow, nvm_rd, nvm_ref_max;
    logic [31:0]           rdata;
    logic [4:0]            nvm_addr, fault_code, manual_addr, self_check_addr;
    logic [5:0]            manual_check;
    emt_pkg::emt_bus_req_s bus_req;
    emt_pkg::emt_nvm_rsp_s nvm_rsp;
    int                    n_errors, n_compared, cyc;

    emt_regs emt_regs_inst (.clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .rdata(rdata),
        .output_disable(output_disable), .nominal_comm_enable(nominal_comm_enable),
        .nominal_comm_allow(nominal_comm_allow), .supply_raised(supply_raised), .nvm_rd(nvm_rd),
        .nvm_addr(nvm_addr), .nvm_ref_max(nvm_ref_max), .nvm_valid(nvm_valid), .nvm_rsp(nvm_rsp),
        .self_check_fail(self_check_fail), .self_check_addr(self_check_addr), .write_fault(write_fault),
        .pump_fault(pump_fault), .fault_code(fault_code), .manual_addr(manual_addr), .manual_check(manual_check),
        .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // one-cycle event pulses; dbe and sbe ride on an unsolicited nvm answer
    task automatic ev(input logic wf, input logic pf, input logic d, input logic s);
        @(posedge clk_sys);
        write_fault <= wf;
        pump_fault <= pf;
        nvm_valid <= d | s;
        nvm_rsp <= '{word: 26'h0, check: 6'h0, sbe: s, dbe: d, bad_min: 1'b0, bad_max: 1'b0};
        @(posedge clk_sys);
        write_fault <= 1'b0;
        pump_fault <= 1'b0;
        nvm_valid <= 1'b0;
        #1;
    endtask

    // waits for one nvm read, checks where it points, answers a cycle later
    task automatic serve(input logic [4:0] a, input logic mx, input logic bad);
        int n;
        n = 0;
        while (nvm_rd !== 1'b1 && n < 50)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk({25'h0, nvm_rd, nvm_ref_max, nvm_addr}, {25'h0, 1'b1, mx, a});
        @(posedge clk_sys);
        nvm_valid <= 1'b1;
        nvm_rsp <= '{word: bad ? 26'h1234567 : 26'h0, check: bad ? 6'h2B : 6'h0, sbe: 1'b0, dbe: 1'b0,
                     bad_min: bad & !mx, bad_max: bad & mx};
        @(posedge clk_sys);
        nvm_valid <= 1'b0;
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    initial
    begin
        rst = 1'b1;
        bus_req = '0;
        nvm_rsp = '0;
        {supply_raised, nvm_valid, write_fault, pump_fault, self_check_fail} = 5'h0;
        self_check_addr = 5'h0;
        fault_code = 5'h15;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) rd(8'h40 + 8'(i), 32'h0);
        rd(8'h48, 32'h0);
        rd(8'h49, 32'h0);
        wr(8'h40, 32'h0040_0001);
        chk({29'h0, output_disable, nominal_comm_enable, nominal_comm_allow}, 32'h7);
        rd(8'h40, 32'h0040_0001);
        wr(8'h40, 32'h0);
        chk({29'h0, output_disable, nominal_comm_enable, nominal_comm_allow}, 32'h0);
        @(posedge clk_sys);
        supply_raised <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk({31'h0, nominal_comm_allow}, 32'h1);
        wr(8'h41, 32'hFFFF_FFFF);
        rd(8'h41, 32'h03FF_FFFF);
        wr(8'h42, 32'h0002_AC00);
        rd(8'h42, 32'h0002_AC00);
        chk({21'h0, manual_check, manual_addr}, 32'h0000_02AC);
        rd(8'h50, 32'h0);
        ev(1'b1, 1'b0, 1'b0, 1'b0);
        rd(8'h42, 32'h0002_ACAC);
        rd(8'h42, 32'h0002_AC00);
        ev(1'b0, 1'b1, 1'b0, 1'b0);
        rd(8'h42, 32'h000A_AC00);
        rd(8'h42, 32'h0002_AC00);
        chk({31'h0, irq}, 32'h0);
        rd(8'h48, 32'h0000_000C);
        rd(8'h48, 32'h0);
        wr(8'h49, 32'h0000_001F);
        ev(1'b0, 1'b0, 1'b1, 1'b0);
        rd(8'h42, 32'h0002_AC01);
        chk({31'h0, irq}, 32'h1);
        rd(8'h48, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0);
        ev(1'b0, 1'b0, 1'b0, 1'b1);
        rd(8'h42, 32'h0002_AC03);
        rd(8'h48, 32'h0000_0002);
        rd(8'h42, 32'h0002_AC03);
        // single pass from a chosen first address, both references
        wr(8'h43, 32'h0000_0EC1);
        fork
            for (int i = 0; i < 6; i++) serve(5'h1D + 5'(i / 2), i[0], 1'b0);
            begin
                repeat (3) @(posedge clk_sys);
                rd(8'h43, 32'h0000_0ED9);
            end
        join
        repeat (2) @(posedge clk_sys);
        rd(8'h43, 32'h0000_0EC8);
        rd(8'h43, 32'h0000_0EC0);
        // min-only single pass from the last address ends after one read
        wr(8'h43, 32'h0000_0FC3);
        serve(5'h1F, 1'b0, 1'b0);
        repeat (2) @(posedge clk_sys);
        rd(8'h43, 32'h0000_0FCA);
        chk({31'h0, irq}, 32'h0);
        // looping max-only test wraps past the last address, then fails
        wr(8'h43, 32'h0000_2005);
        for (int i = 0; i < 33; i++) serve(5'(i), 1'b1, 1'b0);
        serve(5'h01, 1'b1, 1'b1);
        repeat (2) @(posedge clk_sys);
        rd(8'h43, 32'h0000_2034);
        rd(8'h41, 32'h0123_4567);
        rd(8'h42, 32'h0005_6103);
        chk({21'h0, manual_check, manual_addr}, 32'h0000_0561);
        chk({31'h0, irq}, 32'h1);
        rd(8'h48, 32'h0000_0010);
        chk({31'h0, irq}, 32'h0);
        // a self check failure captures word, address and check bits
        @(posedge clk_sys);
        self_check_fail <= 1'b1;
        self_check_addr <= 5'h0A;
        nvm_rsp <= '{word: 26'h2AB_CDEF, check: 6'h15, sbe: 1'b0, dbe: 1'b0, bad_min: 1'b0, bad_max: 1'b0};
        @(posedge clk_sys);
        self_check_fail <= 1'b0;
        #1;
        rd(8'h41, 32'h02AB_CDEF);
        rd(8'h42, 32'h0002_AA03);
        chk({21'h0, manual_check, manual_addr}, 32'h0000_02AA);
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
